/* File: hdl/dec_skip_core.sv */
// Execution of decrement-skip, push and pop over four quarter-phases
`timescale 1ns/1ps
// Behaviour
// - Decrement-skip-if-zero subtracts one from file register, flags untouched.
// - Destination bit clear writes result to W, set writes file register.
// - Zero result discards prefetched instruction, runs a no-operation cycle.
// - Decrement-skip-if-nonzero skips the next instruction on a nonzero result.
// - Skipping a two-word instruction costs two no-operation cycles, three total.
// - Bank bit clear uses access bank, set uses bank selector value.
// - Bank clear, extended set on, address up to 95: indexed literal offset.
// - Pop discards top return-stack entry, exposing the one beneath, one cycle.
// - Push puts program counter plus two on top of the return stack.
// - Push moves the previous top one level down, still kept.
// - One instruction cycle spans four oscillator periods, four quarter-phases.
module dec_skip_core
    import dec_skip_pkg::*;
#(
    parameter int STACK_DEPTH = 31
)
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic instr_valid_in,
    input wire logic [INSTR_W-1:0] instr_in,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic next_two_word_in,
    input wire logic [BANK_W-1:0] bank_selector_value_in,
    input wire logic ext_set_en_in,
    input wire logic [FADDR_W-1:0] index_base_in,
    input wire logic [DATA_W-1:0] file_rdata_in,
    output logic instr_take_out,
    output logic nop_cycle_out,
    output logic [1:0] quarter_out,
    output logic [FADDR_W-1:0] file_addr_out,
    output logic file_rd_out,
    output logic file_we_out,
    output logic [DATA_W-1:0] file_wdata_out,
    output logic [DATA_W-1:0] w_out,
    output logic [PC_W-1:0] top_stack_entry_out,
    output logic [$clog2(STACK_DEPTH+1)-1:0] stack_level_out
);
    localparam int LVL_W = $clog2(STACK_DEPTH + 1);

    quarter_e q_r;
    logic [1:0] skip_cnt_r;
    logic op_dz_r;
    logic op_dnz_r;
    logic dest_f_r;
    logic [PC_W-1:0] pc_r;
    logic [DATA_W-1:0] dec_r;
    logic [FADDR_W-1:0] file_addr_r;
    logic file_rd_r;
    logic file_we_r;
    logic [DATA_W-1:0] file_wdata_r;
    logic [DATA_W-1:0] w_r;
    logic push_r;
    logic pop_r;
    logic pop_pend_r;
    logic take_new;
    logic is_dec;
    logic skip_now;
    logic [FADDR_W-1:0] ea;
    logic [7:0] f;

    stack_if #(.LVL_W(LVL_W)) st ();

    return_stack #(.DEPTH(STACK_DEPTH), .LVL_W(LVL_W)) u_stack (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .st(st.stack)
    );

    assign st.push = push_r;
    assign st.pop = pop_r;
    assign st.push_data = pc_r + PUSH_OFFSET;

    assign quarter_out = q_r;
    assign instr_take_out = (q_r == Q1);
    assign nop_cycle_out = (q_r == Q1) && (skip_cnt_r != 2'h0);
    assign file_addr_out = file_addr_r;
    assign file_rd_out = file_rd_r;
    assign file_we_out = file_we_r;
    assign file_wdata_out = file_wdata_r;
    assign w_out = w_r;
    assign top_stack_entry_out = st.top;
    assign stack_level_out = st.level;

    // A discarded word is consumed but never decoded
    assign take_new = (q_r == Q1) && (skip_cnt_r == 2'h0) && instr_valid_in;
    assign is_dec = (instr_in[15:10] == OPC_DEC_SKIP_ZERO) ||
        (instr_in[15:10] == OPC_DEC_SKIP_NONZERO);
    assign f = instr_in[7:0];
    assign skip_now = (op_dz_r && dec_r == 8'h00) || (op_dnz_r && dec_r != 8'h00);

    always_comb
    begin
        if (instr_in[BANK_BIT])
        begin
            ea = {bank_selector_value_in, f};
        end
        else if (ext_set_en_in && f <= INDEXED_MAX)
        begin
            ea = index_base_in + {4'h0, f};
        end
        else
        begin
            ea = {(f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            q_r <= Q1;
        end
        else
        begin
            q_r <= quarter_e'(q_r + 2'h1);
        end
    end

    // Decode at the end of Q1; anything not ours runs as a plain cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            op_dz_r <= 1'b0;
            op_dnz_r <= 1'b0;
            dest_f_r <= 1'b1;
            pc_r <= STACK_RESET;
        end
        else if (q_r == Q1)
        begin
            op_dz_r <= take_new && instr_in[15:10] == OPC_DEC_SKIP_ZERO;
            op_dnz_r <= take_new && instr_in[15:10] == OPC_DEC_SKIP_NONZERO;
            dest_f_r <= instr_in[DEST_BIT];
            pc_r <= pc_in;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            file_addr_r <= '0;
            file_rd_r <= 1'b0;
        end
        else
        begin
            file_rd_r <= take_new && is_dec;
            if (take_new && is_dec)
            begin
                file_addr_r <= ea;
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            dec_r <= 8'h00;
        end
        else if (q_r == Q2 && file_rd_r)
        begin
            dec_r <= file_rdata_in - DEC_STEP;
        end
    end

    // Result lands during Q4; no status flag is touched
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            file_we_r <= 1'b0;
            file_wdata_r <= 8'h00;
            w_r <= W_RESET;
        end
        else
        begin
            file_we_r <= (q_r == Q3) && (op_dz_r || op_dnz_r) && dest_f_r;
            if (q_r == Q3 && (op_dz_r || op_dnz_r))
            begin
                if (dest_f_r)
                begin
                    file_wdata_r <= dec_r;
                end
                else
                begin
                    w_r <= dec_r;
                end
            end
        end
    end

    // Decided at end of Q3 so the next Q1 already sees the discard
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            skip_cnt_r <= 2'h0;
        end
        else if (q_r == Q3 && skip_now)
        begin
            skip_cnt_r <= next_two_word_in ? 2'h2 : 2'h1;
        end
        else if (q_r == Q1 && skip_cnt_r != 2'h0)
        begin
            skip_cnt_r <= skip_cnt_r - 2'h1;
        end
    end

    // Push in Q2, pop in Q3, each a single strobe
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            push_r <= 1'b0;
            pop_r <= 1'b0;
        end
        else
        begin
            push_r <= take_new && instr_in == OPC_PUSH;
            pop_r <= (q_r == Q2) && pop_pend_r;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            pop_pend_r <= 1'b0;
        end
        else
        begin
            pop_pend_r <= take_new && instr_in == OPC_POP;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    quarter_walk_a: assert property (
        q_r == Q1 |=> q_r == Q2 ##1 q_r == Q3 ##1 q_r == Q4 ##1 q_r == Q1)
        else $error("quarter phases out of order");
    dec_value_a: assert property (
        file_we_r |-> file_wdata_r == $past(file_rdata_in, 2) - DEC_STEP)
        else $error("written value is not read value minus one");
    dest_w_a: assert property (
        (q_r == Q3 && (op_dz_r || op_dnz_r) && !dest_f_r) |=> !file_we_r && w_r == $past(dec_r))
        else $error("destination W not honoured");
    skip_zero_a: assert property (
        (q_r == Q3 && op_dz_r && dec_r == 8'h00) |-> ##2 nop_cycle_out)
        else $error("zero result did not skip");
    skip_nonzero_a: assert property (
        (q_r == Q3 && op_dnz_r && dec_r != 8'h00) |-> ##2 nop_cycle_out)
        else $error("nonzero result did not skip");
    skip_two_word_a: assert property (
        (q_r == Q3 && skip_now && next_two_word_in) |-> ##2 nop_cycle_out ##4 nop_cycle_out
        ##4 !nop_cycle_out)
        else $error("two-word skip not two no-op cycles");
    bank_addr_a: assert property (
        (take_new && is_dec && instr_in[BANK_BIT]) |=>
        file_rd_r && file_addr_r == {$past(bank_selector_value_in), $past(f)})
        else $error("banked address wrong");
    indexed_addr_a: assert property (
        (take_new && is_dec && !instr_in[BANK_BIT] && ext_set_en_in && f <= INDEXED_MAX) |=>
        file_addr_r == $past(index_base_in) + {4'h0, $past(f)})
        else $error("indexed address wrong");
    phase_order_a: assert property (
        file_rd_r |-> q_r == Q2 ##2 (q_r == Q4))
        else $error("read outside Q2");
    push_value_a: assert property (
        (take_new && instr_in == OPC_PUSH) |=> push_r && st.push_data == $past(pc_in) + PUSH_OFFSET)
        else $error("push value not pc plus two");
    pop_once_a: assert property (
        (take_new && instr_in == OPC_POP) |-> ##2 pop_r ##1 !pop_r)
        else $error("pop strobe missing");

    cover_skip_zero: cover property (q_r == Q3 && op_dz_r && dec_r == 8'h00);
    cover_two_word: cover property (q_r == Q3 && skip_now && next_two_word_in);
    cover_push_pop: cover property (push_r ##[1:8] pop_r);
endmodule

/* File: hdl/dec_skip_pkg.sv */
// Shared constants for the decrement-skip and return-stack execution logic
package dec_skip_pkg;
    localparam int INSTR_W = 16;
    localparam int PC_W = 21;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 12;
    localparam int BANK_W = 4;
    // Quarter-phases per instruction cycle at one clock per oscillator period
    localparam int QUARTER_COUNT = 4;
    localparam logic [5:0] OPC_DEC_SKIP_ZERO = 6'h0b;
    localparam logic [5:0] OPC_DEC_SKIP_NONZERO = 6'h13;
    localparam logic [15:0] OPC_PUSH = 16'h0005;
    localparam logic [15:0] OPC_POP = 16'h0006;
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [20:0] PUSH_OFFSET = 21'h00_0002;
    localparam logic [7:0] DEC_STEP = 8'h01;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [20:0] STACK_RESET = 21'h00_0000;
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_e;
endpackage

/* File: hdl/return_stack.sv */
// Hardware return stack with registered top entry
`timescale 1ns/1ps
module return_stack
    import dec_skip_pkg::*;
#(
    parameter int DEPTH = 31,
    parameter int LVL_W = 5
)
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    stack_if.stack st
);
    logic [PC_W-1:0] mem [DEPTH];
    logic [LVL_W-1:0] level_r;
    logic [PC_W-1:0] top_r;

    assign st.top = top_r;
    assign st.level = level_r;

    // Full pushes and empty pops are dropped rather than wrapping
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            level_r <= '0;
        end
        else if (st.push && level_r != LVL_W'(DEPTH))
        begin
            level_r <= level_r + LVL_W'(1);
        end
        else if (st.pop && level_r != '0)
        begin
            level_r <= level_r - LVL_W'(1);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (st.push && level_r != LVL_W'(DEPTH))
        begin
            mem[level_r] <= st.push_data;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            top_r <= STACK_RESET;
        end
        else if (st.push && level_r != LVL_W'(DEPTH))
        begin
            top_r <= st.push_data;
        end
        else if (st.pop && level_r != '0)
        begin
            top_r <= (level_r >= LVL_W'(2)) ? mem[level_r - LVL_W'(2)] : STACK_RESET;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    push_top_a: assert property (
        (st.push && level_r < LVL_W'(DEPTH)) |=> top_r == $past(st.push_data))
        else $error("push did not load top entry");
    push_keep_a: assert property (
        (st.push && level_r < LVL_W'(DEPTH) && level_r != '0) |=>
        (level_r == $past(level_r) + LVL_W'(1)) && mem[level_r - LVL_W'(2)] == $past(top_r))
        else $error("push lost previous top");
    pop_top_a: assert property (
        (st.pop && !st.push && level_r >= LVL_W'(2)) |=>
        (level_r == $past(level_r) - LVL_W'(1)) && top_r == mem[level_r - LVL_W'(1)])
        else $error("pop did not expose previous entry");
endmodule

/* File: hdl/stack_if.sv */
// Command and state link between the core sequencer and the return stack
`timescale 1ns/1ps
interface stack_if #(parameter int LVL_W = 5);
    import dec_skip_pkg::*;
    logic push;
    logic pop;
    logic [PC_W-1:0] push_data;
    logic [PC_W-1:0] top;
    logic [LVL_W-1:0] level;
    modport core (output push, output pop, output push_data, input top, input level);
    modport stack (input push, input pop, input push_data, output top, output level);
endinterface

/* File: tb/decrement_skip_and_stack_ops_tb.sv */
// Self-checking bench for decrement-skip, push and pop execution
`timescale 1ns/1ps
module decrement_skip_and_stack_ops_tb;
    import dec_skip_pkg::*;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic instr_valid_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic [20:0] pc_in = 21'h00_0000;
    logic next_two_word_in = 1'b0;
    logic [3:0] bank_selector_value_in = 4'h0;
    logic ext_set_en_in = 1'b0;
    logic [11:0] index_base_in = 12'h000;
    logic [7:0] file_rdata_in = 8'h00;
    logic instr_take_out;
    logic nop_cycle_out;
    logic [1:0] quarter_out;
    logic [11:0] file_addr_out;
    logic file_rd_out;
    logic file_we_out;
    logic [7:0] file_wdata_out;
    logic [7:0] w_out;
    logic [20:0] top_stack_entry_out;
    logic [4:0] stack_level_out;
    int n_fail = 0;
    int n_compared = 0;
    logic [20:0] stk[$];
    logic [7:0] w_model = 8'h00;

    always #4 clk_sys_in = ~clk_sys_in;

    dec_skip_core #(.STACK_DEPTH(31)) i_dec_skip_core (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .pc_in(pc_in), .next_two_word_in(next_two_word_in),
        .bank_selector_value_in(bank_selector_value_in), .ext_set_en_in(ext_set_en_in),
        .index_base_in(index_base_in), .file_rdata_in(file_rdata_in),
        .instr_take_out(instr_take_out), .nop_cycle_out(nop_cycle_out),
        .quarter_out(quarter_out), .file_addr_out(file_addr_out), .file_rd_out(file_rd_out),
        .file_we_out(file_we_out), .file_wdata_out(file_wdata_out), .w_out(w_out),
        .top_stack_entry_out(top_stack_entry_out), .stack_level_out(stack_level_out)
    );

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (exp !== got)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [11:0] exp_addr(input logic [15:0] ins);
        logic [7:0] f;
        f = ins[7:0];
        if (ins[BANK_BIT])
            return {bank_selector_value_in, f};
        else if (ext_set_en_in && f <= INDEXED_MAX)
            return index_base_in + {4'h0, f};
        else if (f < ACCESS_SPLIT)
            return {ACCESS_LOW_BANK, f};
        return {ACCESS_HIGH_BANK, f};
    endfunction

    function automatic logic [20:0] top_model();
        return (stk.size() == 0) ? STACK_RESET : stk[$];
    endfunction

    // One instruction from its Q1 slot up to the next free Q1 slot
    task automatic do_instr(input logic [15:0] ins, input logic tw, input logic [7:0] rd);
        logic is_z;
        logic is_nz;
        logic is_dec;
        logic d;
        logic skip;
        logic [7:0] res;
        logic [20:0] pc;
        int guard;
        guard = 0;
        while (quarter_out !== 2'h0 && guard < 8)
        begin
            @(negedge clk_sys_in);
            guard++;
        end
        check("quarter", 0, quarter_out);
        check("nop_cycle", 0, nop_cycle_out);
        check("instr_take", 1, instr_take_out);
        pc = 21'($urandom);
        instr_in = ins;
        pc_in = pc;
        next_two_word_in = tw;
        file_rdata_in = rd;
        instr_valid_in = 1'b1;
        is_z = (ins[15:10] === OPC_DEC_SKIP_ZERO);
        is_nz = (ins[15:10] === OPC_DEC_SKIP_NONZERO);
        is_dec = is_z | is_nz;
        d = ins[DEST_BIT];
        res = rd - DEC_STEP;
        skip = (is_z && res == 8'h00) || (is_nz && res != 8'h00);
        @(negedge clk_sys_in);
        check("quarter", 1, quarter_out);
        check("instr_take", 0, instr_take_out);
        check("file_rd", is_dec, file_rd_out);
        if (is_dec)
            check("file_addr", exp_addr(ins), file_addr_out);
        @(negedge clk_sys_in);
        check("quarter", 2, quarter_out);
        check("file_rd", 0, file_rd_out);
        if (ins === OPC_PUSH)
        begin
            if (stk.size() < 31)
                stk.push_back(pc + PUSH_OFFSET);
            check("top", top_model(), top_stack_entry_out);
            check("level", stk.size(), stack_level_out);
        end
        @(negedge clk_sys_in);
        check("quarter", 3, quarter_out);
        if (ins === OPC_POP && stk.size() > 0)
            void'(stk.pop_back());
        check("top", top_model(), top_stack_entry_out);
        check("level", stk.size(), stack_level_out);
        check("file_we", is_dec && d, file_we_out);
        if (is_dec && d)
            check("file_wdata", res, file_wdata_out);
        if (is_dec && !d)
            w_model = res;
        @(negedge clk_sys_in);
        check("w", w_model, w_out);
        if (skip)
        begin
            // Offer a push in the discarded slots: it must leave the stack alone
            instr_in = OPC_PUSH;
            repeat (tw ? 2 : 1)
            begin
                check("nop_cycle", 1, nop_cycle_out);
                repeat (4) @(negedge clk_sys_in);
                check("level", stk.size(), stack_level_out);
            end
        end
    endtask

    task automatic dec_op(input logic z, input logic d, input logic a, input logic [7:0] f,
                          input logic [7:0] rd, input logic tw);
        do_instr({z ? OPC_DEC_SKIP_ZERO : OPC_DEC_SKIP_NONZERO, d, a, f}, tw, rd);
    endtask

    initial
    begin
        #200_000;
        n_fail++;
        results();
    end

    initial
    begin
        void'($urandom(32'h11c3fad7));
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check("quarter", 0, quarter_out);
        check("w", 0, w_out);
        check("level", 0, stack_level_out);
        nrst_in = 1'b1;
        @(negedge clk_sys_in);
        bank_selector_value_in = 4'h5;
        ext_set_en_in = 1'b1;
        index_base_in = 12'hf80;
        dec_op(1, 1, 1, 8'h10, 8'h01, 0);
        dec_op(1, 0, 0, 8'h5f, 8'h01, 1);
        dec_op(1, 0, 0, 8'h60, 8'h00, 0);
        dec_op(0, 1, 0, 8'h00, 8'h00, 1);
        dec_op(0, 0, 1, 8'hff, 8'h01, 1);
        ext_set_en_in = 1'b0;
        dec_op(0, 1, 0, 8'h5f, 8'h02, 0);
        dec_op(1, 1, 0, 8'h60, 8'h01, 1);
        // Word offered without valid must not start a read or a skip
        instr_valid_in = 1'b0;
        instr_in = {OPC_DEC_SKIP_ZERO, 2'b11, 8'h01};
        @(negedge clk_sys_in);
        check("file_rd", 0, file_rd_out);
        repeat (2) @(negedge clk_sys_in);
        check("file_we", 0, file_we_out);
        @(negedge clk_sys_in);
        check("nop_cycle", 0, nop_cycle_out);
        do_instr(16'hffff, 0, 8'h01);
        repeat (33) do_instr(OPC_POP, 0, 8'h00);
        repeat (32) do_instr(OPC_PUSH, 0, 8'h00);
        repeat (33) do_instr(OPC_POP, 0, 8'h00);
        repeat (200)
        begin
            bank_selector_value_in = 4'($urandom);
            ext_set_en_in = 1'($urandom);
            index_base_in = 12'($urandom);
            case ($urandom_range(0, 3))
                0: do_instr(OPC_PUSH, 0, 8'h00);
                1: do_instr(OPC_POP, 0, 8'h00);
                default: dec_op(1'($urandom), 1'($urandom), 1'($urandom), 8'($urandom),
                                ($urandom_range(0, 2) == 0) ? 8'h01 : 8'($urandom),
                                1'($urandom));
            endcase
        end
        results();
    end
endmodule
